// ---- hdl/timer2_consts.svh ----
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// Register byte addresses
`define OFF_CONTROL 12'h000
`define OFF_COUNT 12'h004
`define OFF_CAPTURE 12'h008
`define OFF_STATUS 12'h00C
`define OFF_MASK 12'h010

// Control register field positions
`define CTL_RUN 0
`define CTL_TCSEL 1
`define CTL_CAPSEL 2
`define CTL_TRIGEN 3
`define CTL_RXCLK 4
`define CTL_TXCLK 5
`define CTL_WIDTH 6

// Status/mask field positions
`define ST_OVF 0
`define ST_EXT 1

// Reset values
`define CONTROL_RST 6'h00
`define COUNT_RST 16'h0000

// Machine-cycle timing: 12 oscillator periods per machine cycle
`define OSC_PER_MC 12
`define MC_CNT_MAX 4'hB
`define SAMPLE_PHASE 4'h9
`define UPDATE_PHASE 4'h4

`endif

// ---- hdl/timer2_pkg.sv ----
`default_nettype none

package timer2_pkg;
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_CAPTURE,
        MODE_RELOAD,
        MODE_BAUD
    } mode_t;
endpackage

`default_nettype wire

// ---- hdl/timer2_capture_counter.sv ----
`include "timer2_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module timer2_capture_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // External pins
    input wire logic externalCountInput,
    input wire logic externalTriggerInput,
    // Interrupt
    output logic irq
);

    // Decodes an APB access to one register offset
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // Pin synchronisers
    logic cntSync1_r, cntSync2_r, trgSync1_r, trgSync2_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            cntSync1_r <= 1'b1;
            cntSync2_r <= 1'b1;
            trgSync1_r <= 1'b1;
            trgSync2_r <= 1'b1;
        end else begin
            cntSync1_r <= externalCountInput;
            cntSync2_r <= cntSync1_r;
            trgSync1_r <= externalTriggerInput;
            trgSync2_r <= trgSync1_r;
        end
    end

    // State
    logic [3:0] phase_r, phase_nxt;
    logic [`CTL_WIDTH-1:0] control_r, control_nxt;
    logic [7:0] countHighByte_r, countHighByte_nxt;
    logic [7:0] countLowByte_r, countLowByte_nxt;
    logic [7:0] captureHighByte_r, captureHighByte_nxt;
    logic [7:0] captureLowByte_r, captureLowByte_nxt;
    logic [1:0] status_r, status_nxt;
    logic [1:0] mask_r, mask_nxt;
    logic cntSample_r, cntSample_nxt;
    logic cntPending_r, cntPending_nxt;
    logic trgPrev_r, trgPrev_nxt;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt, irq_nxt;

    // Derived controls
    timer2_pkg::mode_t mode;
    logic setup, wrEn, mapped, samplePoint, updatePoint, step, trigFall, overflow;
    logic [15:0] countNext;

    always_comb begin
        // Mode decode per the select table
        if (!control_r[`CTL_RUN]) begin
            mode = timer2_pkg::MODE_OFF;
        end else if (control_r[`CTL_RXCLK] | control_r[`CTL_TXCLK]) begin
            mode = timer2_pkg::MODE_BAUD;
        end else if (control_r[`CTL_CAPSEL]) begin
            mode = timer2_pkg::MODE_CAPTURE;
        end else begin
            mode = timer2_pkg::MODE_RELOAD;
        end
    end

    // Bus access qualifiers; slave answers in the access phase with no waits
    assign setup = psel & ~penable;
    assign wrEn = psel & penable & pwrite;
    assign mapped = hit(paddr, `OFF_CONTROL) | hit(paddr, `OFF_COUNT) | hit(paddr, `OFF_CAPTURE)
        | hit(paddr, `OFF_STATUS) | hit(paddr, `OFF_MASK);

    // Machine-cycle phase points
    assign samplePoint = (phase_r == `SAMPLE_PHASE);
    assign updatePoint = (phase_r == `UPDATE_PHASE);

    // Count step: timer once per machine cycle, counter on a detected fall
    // Only capture mode counts here; reload and baud datapaths are not built
    assign step = (mode == timer2_pkg::MODE_CAPTURE) & updatePoint
        & (control_r[`CTL_TCSEL] ? cntPending_r : 1'b1);
    assign countNext = {countHighByte_r, countLowByte_r} + 16'h0001;
    assign overflow = step & ({countHighByte_r, countLowByte_r} == 16'hFFFF);
    assign trigFall = trgPrev_r & ~trgSync2_r & (mode == timer2_pkg::MODE_CAPTURE)
        & control_r[`CTL_TRIGEN];

    always_comb begin
        phase_nxt = (phase_r == `MC_CNT_MAX) ? 4'h0 : phase_r + 4'h1;
        control_nxt = control_r;
        countHighByte_nxt = countHighByte_r;
        countLowByte_nxt = countLowByte_r;
        captureHighByte_nxt = captureHighByte_r;
        captureLowByte_nxt = captureLowByte_r;
        status_nxt = status_r;
        mask_nxt = mask_r;
        cntSample_nxt = cntSample_r;
        cntPending_nxt = cntPending_r;
        trgPrev_nxt = trgSync2_r;

        // Counter input: one sample per machine cycle; a fall waits for next update
        if (samplePoint) begin
            cntSample_nxt = cntSync2_r;
            if (cntSample_r & ~cntSync2_r) begin
                cntPending_nxt = 1'b1;
            end
        end
        if (updatePoint) begin
            cntPending_nxt = 1'b0;
        end

        // Software writes; hardware steps below take priority over them
        if (wrEn) begin
            if (hit(paddr, `OFF_CONTROL)) begin
                control_nxt = pwdata[`CTL_WIDTH-1:0];
            end
            if (hit(paddr, `OFF_COUNT)) begin
                countHighByte_nxt = pwdata[15:8];
                countLowByte_nxt = pwdata[7:0];
            end
            if (hit(paddr, `OFF_CAPTURE)) begin
                captureHighByte_nxt = pwdata[15:8];
                captureLowByte_nxt = pwdata[7:0];
            end
            if (hit(paddr, `OFF_STATUS)) begin
                status_nxt = status_r & ~pwdata[1:0];
            end
            if (hit(paddr, `OFF_MASK)) begin
                mask_nxt = pwdata[1:0];
            end
        end

        // Low byte carries into high byte
        if (step) begin
            countHighByte_nxt = countNext[15:8];
            countLowByte_nxt = countNext[7:0];
        end
        if (trigFall) begin
            captureHighByte_nxt = countHighByte_r;
            captureLowByte_nxt = countLowByte_r;
        end
        // Set beats a same-cycle clear
        if (overflow) begin
            status_nxt[`ST_OVF] = 1'b1;
        end
        if (trigFall) begin
            status_nxt[`ST_EXT] = 1'b1;
        end

        // Read mux, registered into prdata at the setup edge
        prdata_nxt = 32'h0000_0000;
        if (setup & ~pwrite) begin
            if (hit(paddr, `OFF_CONTROL)) begin
                prdata_nxt = {26'h0, control_r};
            end else if (hit(paddr, `OFF_COUNT)) begin
                prdata_nxt = {16'h0, countHighByte_r, countLowByte_r};
            end else if (hit(paddr, `OFF_CAPTURE)) begin
                prdata_nxt = {16'h0, captureHighByte_r, captureLowByte_r};
            end else if (hit(paddr, `OFF_STATUS)) begin
                prdata_nxt = {30'h0, status_r};
            end else if (hit(paddr, `OFF_MASK)) begin
                prdata_nxt = {30'h0, mask_r};
            end
        end
        pready_nxt = setup;
        pslverr_nxt = setup & ~mapped;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_r <= 4'h0;
            control_r <= `CONTROL_RST;
            countHighByte_r <= 8'h00;
            countLowByte_r <= 8'h00;
            captureHighByte_r <= 8'h00;
            captureLowByte_r <= 8'h00;
            status_r <= 2'h0;
            mask_r <= 2'h0;
            cntSample_r <= 1'b0;
            cntPending_r <= 1'b0;
            trgPrev_r <= 1'b1;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            control_r <= control_nxt;
            countHighByte_r <= countHighByte_nxt;
            countLowByte_r <= countLowByte_nxt;
            captureHighByte_r <= captureHighByte_nxt;
            captureLowByte_r <= captureLowByte_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            cntSample_r <= cntSample_nxt;
            cntPending_r <= cntPending_nxt;
            trgPrev_r <= trgPrev_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
            irq <= irq_nxt;
        end
    end

    // Checks
    sequence fallSeen_s;
        samplePoint && cntSample_r && !cntSync2_r;
    endsequence

    timer_step_a: assert property (@(posedge clk) disable iff (reset)
        (mode == timer2_pkg::MODE_CAPTURE && !control_r[`CTL_TCSEL] && updatePoint && !wrEn)
        |=> {countHighByte_r, countLowByte_r} == $past({countHighByte_r, countLowByte_r}) + 16'h0001)
        else $error("timer did not step at update phase");
    off_hold_a: assert property (@(posedge clk) disable iff (reset)
        (!control_r[`CTL_RUN] && !wrEn) |=> $stable({countHighByte_r, countLowByte_r}))
        else $error("counter moved while off");
    edge_pend_a: assert property (@(posedge clk) disable iff (reset)
        fallSeen_s |=> cntPending_r)
        else $error("falling count edge not recorded");
    update_delay_a: assert property (@(posedge clk) disable iff (reset)
        fallSeen_s |-> ##7 updatePoint)
        else $error("update phase not seven clocks after sample");
    phase_wrap_a: assert property (@(posedge clk) disable iff (reset)
        samplePoint |=> !samplePoint [*8] ##1 !samplePoint [*3] ##1 samplePoint)
        else $error("sample phase not once per machine cycle");
    overflow_flag_a: assert property (@(posedge clk) disable iff (reset)
        overflow |=> status_r[`ST_OVF] && countLowByte_r == 8'h00 && countHighByte_r == 8'h00)
        else $error("overflow did not wrap and flag");
    capture_copy_a: assert property (@(posedge clk) disable iff (reset)
        trigFall && !step |=> {captureHighByte_r, captureLowByte_r} == $past({countHighByte_r, countLowByte_r}))
        else $error("capture did not copy count");
    event_flag_a: assert property (@(posedge clk) disable iff (reset)
        trigFall |=> status_r[`ST_EXT])
        else $error("event flag not set on capture");
    irq_level_a: assert property (@(posedge clk) disable iff (reset)
        ##1 irq == |(status_r & mask_r))
        else $error("interrupt does not follow flags");
    flag_sticky_a: assert property (@(posedge clk) disable iff (reset)
        (status_r[`ST_OVF] && !(wrEn && hit(paddr, `OFF_STATUS))) |=> status_r[`ST_OVF])
        else $error("overflow flag cleared without software");

    // Counter input path: a recorded fall lands at the next update point
    sequence pendingStep_s;
        mode == timer2_pkg::MODE_CAPTURE && control_r[`CTL_TCSEL] && cntPending_r && updatePoint && !wrEn;
    endsequence

    count_step_a: assert property (@(posedge clk) disable iff (reset)
        pendingStep_s |=> {countHighByte_r, countLowByte_r} == $past({countHighByte_r, countLowByte_r}) + 16'h0001)
        else $error("counted edge not applied at update phase");
    count_idle_a: assert property (@(posedge clk) disable iff (reset)
        (control_r[`CTL_TCSEL] && !cntPending_r && !wrEn) |=> $stable({countHighByte_r, countLowByte_r}))
        else $error("counter moved without a recorded fall");
    sample_track_a: assert property (@(posedge clk) disable iff (reset)
        samplePoint |=> cntSample_r == $past(cntSync2_r))
        else $error("count input not sampled at sample phase");
    sample_hold_a: assert property (@(posedge clk) disable iff (reset)
        !samplePoint |=> $stable(cntSample_r))
        else $error("count input sampled outside sample phase");
    phase_range_a: assert property (@(posedge clk) disable iff (reset)
        phase_r <= `MC_CNT_MAX)
        else $error("machine cycle phase out of range");

    // Capture and flag paths: nothing moves without its own event
    capture_hold_a: assert property (@(posedge clk) disable iff (reset)
        (!control_r[`CTL_TRIGEN] && !(wrEn && hit(paddr, `OFF_CAPTURE)))
        |=> $stable({captureHighByte_r, captureLowByte_r}))
        else $error("capture changed with trigger disabled");
    trig_edge_a: assert property (@(posedge clk) disable iff (reset)
        trigFall |-> $past(trgSync2_r) && !trgSync2_r)
        else $error("capture without a trigger fall");
    ext_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!status_r[`ST_EXT] && !trigFall) |=> !status_r[`ST_EXT])
        else $error("event flag set without a capture edge");
    ovf_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!status_r[`ST_OVF] && !overflow) |=> !status_r[`ST_OVF])
        else $error("overflow flag set without a wrap");

endmodule

`default_nettype wire

// ---- tb/ext_pin_source.sv ----
`timescale 1ns/10ps
`default_nettype none

module ext_pin_source (
    // Clock
    input wire logic clk,
    // Pins toward the timer
    output logic countPin,
    output logic trigPin
);
    // Port pins have pull-ups, so both idle high between events
    initial begin
        countPin = 1'b1;
        trigPin = 1'b1;
    end

    // Count pulses; each level stands at least one machine cycle
    task automatic pulses(input int n, input int hold);
        repeat (n) begin
            countPin <= 1'b0;
            repeat (hold) @(posedge clk);
            countPin <= 1'b1;
            repeat (hold) @(posedge clk);
        end
    endtask

    // One trigger fall, low and high levels one machine cycle each
    task automatic trigFall();
        trigPin <= 1'b0;
        repeat (12) @(posedge clk);
        trigPin <= 1'b1;
        repeat (12) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "timer2_consts.svh"

module tb_top;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, irq, countPin, trigPin, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [31:0] seed = 32'hC80A44A6;
    logic [5:0] ctlTab [7] = '{6'h01, 6'h04, 6'h05, 6'h15, 6'h25, 6'h35, 6'h00};
    int nMismatch = 0;
    int samplesChecked = 0;
    int n;

    timer2_capture_counter i_timer2_capture_counter(.clk(clk), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .externalCountInput(countPin),
        .externalTriggerInput(trigPin), .irq(irq));
    ext_pin_source i_ext_pin_source(.clk(clk), .countPin(countPin), .trigPin(trigPin));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Only capture mode with run set advances the timer
    function automatic logic [31:0] ticks(input logic [5:0] c, input int span);
        return (c[0] && c[2] && !c[4] && !c[5] && !c[1]) ? span / 12 : 0;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            nMismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; data taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a hang here
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic err;
        apb(1'b1, a, d, q, err);
    endtask

    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic err;
        apb(1'b0, a, 32'h0, q, err);
        chk(what, exp, q);
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
        if (nMismatch == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Main sequence; every step starts just after a rising edge
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdc("control", `OFF_CONTROL, 32'h0);
        rdc("count", `OFF_COUNT, 32'h0);
        apb(1'b0, 12'h014, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, rd);
        // Each mode runs 60 clocks between the two control writes
        foreach (ctlTab[i]) begin
            wr(`OFF_COUNT, 32'h0);
            wr(`OFF_CONTROL, {26'h0, ctlTab[i]});
            repeat (57) @(posedge clk);
            wr(`OFF_CONTROL, 32'h0);
            rdc("mode count", `OFF_COUNT, ticks(ctlTab[i], 60));
        end
        // Carry from low byte: one machine cycle of timer
        // High byte kept below all ones, so no overflow flag is left behind
        v = {16'h0, 8'(rnd() % 255), 8'hFF};
        wr(`OFF_COUNT, v);
        wr(`OFF_CONTROL, 32'h5);
        repeat (9) @(posedge clk);
        wr(`OFF_CONTROL, 32'h0);
        rdc("carry", `OFF_COUNT, v + 1);
        // Event counting, first at the fastest legal rate
        for (int r = 0; r < 2; r++) begin
            n = 2 + rnd() % 6;
            wr(`OFF_COUNT, 32'h0);
            wr(`OFF_CONTROL, 32'h7);
            i_ext_pin_source.pulses(n, r == 0 ? 12 : 12 + rnd() % 9);
            repeat (40) @(posedge clk);
            rdc("events", `OFF_COUNT, n);
        end
        // Trigger ignored while disabled, captures once enabled
        i_ext_pin_source.trigFall();
        rdc("no capture", `OFF_CAPTURE, 32'h0);
        rdc("no flag", `OFF_STATUS, 32'h0);
        wr(`OFF_CONTROL, 32'hF);
        i_ext_pin_source.trigFall();
        rdc("capture", `OFF_CAPTURE, n);
        rdc("event flag", `OFF_STATUS, 32'h2);
        wr(`OFF_MASK, 32'h3);
        chk("irq event", 32'h1, {31'h0, irq});
        wr(`OFF_STATUS, 32'h2);
        rdc("flag cleared", `OFF_STATUS, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Overflow: two increments from all ones wrap to one
        wr(`OFF_CONTROL, 32'h0);
        wr(`OFF_COUNT, 32'hFFFF);
        wr(`OFF_CONTROL, 32'h5);
        repeat (21) @(posedge clk);
        wr(`OFF_CONTROL, 32'h0);
        rdc("wrap", `OFF_COUNT, 32'h1);
        rdc("overflow flag", `OFF_STATUS, 32'h1);
        chk("irq overflow", 32'h1, {31'h0, irq});
        wr(`OFF_MASK, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdc("flag sticky", `OFF_STATUS, 32'h1);
        endOfTest();
    end

    // Watchdog well beyond the roughly 860 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        nMismatch++;
        endOfTest();
    end
endmodule

`default_nettype wire
